// File: pcm_channel.v
// Per-channel mode control and data path steering
`timescale 1ns/1ps
`include "pcm_map.vh"

module pcm_channel #(
   parameter DW       = 16,
   parameter AW       = 3,
   parameter CW       = 6,
   parameter PD_COUNT = `PCM_PD_CYCLES
) (
   // Clock and reset
   input  wire          core_clk,
   input  wire          rst_n,
   // Mode selection
   input  wire          path_rst,
   input  wire [2:0]    mode_sel,
   input  wire [2:0]    rpt_rate_sel,
   input  wire [1:0]    refsel_pins,
   input  wire          stages_en,
   input  wire          mac_en,
   input  wire          loopback_en,
   // Receive parallel data from line
   input  wire          rx_valid,
   input  wire [DW-1:0] rx_data,
   // Host side parallel output
   output reg           host_valid_q,
   output reg  [DW-1:0] host_data_q,
   // Line transmit parallel input and output
   input  wire          tx_valid,
   input  wire [DW-1:0] tx_data,
   output reg           line_valid_q,
   output reg  [DW-1:0] line_data_q,
   // Status of routing
   output reg  [2:0]    rx_route_q,
   output reg  [2:0]    line_rate_q,
   output reg  [2:0]    host_rate_q,
   output reg           ref_sel_q,
   output reg           stage_bypass_q,
   output reg           rate_fifo_sel_q,
   output reg           elastic_ovf_q,
   // Signal monitor
   input  wire          monitor_req,
   input  wire          monitor_unity,
   output reg           monitor_on_q,
   output reg           dfe_zero_q,
   output reg           adapt_en_q,
   // Negotiation
   input  wire          an_line_req,
   input  wire          an_host_req,
   input  wire [1:0]    an_mgmt_mode,
   input  wire          an_force_1g,
   input  wire          partner_adv_10g,
   input  wire          partner_adv_1g,
   input  wire          partner_an_seen,
   input  wire          sig_10g_lock,
   input  wire          sig_1g_lock,
   output reg           an_line_on_q,
   output reg           an_host_on_q,
   output reg           cru_1g_sel_q,
   output reg           an_done_q,
   // Serial transmit equalizer
   input  wire          ser_bit_en,
   input  wire          ser_bit,
   input  wire [CW-1:0] coef_pre,
   input  wire [CW-1:0] coef_main,
   input  wire [CW-1:0] coef_post,
   output wire [CW+1:0] fir_drive_q
);
   localparam DEPTH = 1 << AW;

   // Negotiation states
   localparam AN_IDLE  = 2'h0;
   localparam AN_WAIT  = 2'h1;
   localparam AN_DONE  = 2'h2;

   // ----------------------------------------------------------------
   // Mode decode and rate selection
   // ----------------------------------------------------------------
   reg [2:0] mode_q;
   reg       ref_caught_q;

   // Serial rate of a repeater sub rate, same on both sides
   function [2:0] rpt_rate;
      input [2:0] r;
      begin
         case (r)
            `PCM_RPT_GBE:   rpt_rate = `PCM_RATE_1G25;
            `PCM_RPT_OTU2:  rpt_rate = `PCM_RATE_10G7;
            `PCM_RPT_OTU1E: rpt_rate = `PCM_RATE_11G05;
            `PCM_RPT_OTU2E: rpt_rate = `PCM_RATE_11G1;
            default:        rpt_rate = `PCM_RATE_10G3;
         endcase
      end
   endfunction

   wire is_rpt = (mode_q == `PCM_MODE_RPT);
   // A LAN channel negotiated down to 1G counts as 1G for the monitor
   wire is_1g  = (mode_q == `PCM_MODE_GBE) || (is_rpt && rpt_rate_sel == `PCM_RPT_GBE)
               || (mode_q == `PCM_MODE_LAN && cru_1g_sel_q && an_done_q);
   wire run    = !path_rst;

   // Mode latched only while path is in reset; strap caught after release
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_q       <= `PCM_MODE_LAN;
         ref_caught_q <= 1'b0;
         ref_sel_q    <= `PCM_REF_156M25;
      end else begin
         if (path_rst)
            mode_q <= mode_sel;
         if (!ref_caught_q) begin
            ref_caught_q <= 1'b1;
            ref_sel_q    <= (refsel_pins == 2'b10) ? `PCM_REF_125M
                                                  : `PCM_REF_156M25;
         end
      end
   end

   // Route and rate outputs follow the latched mode
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_route_q      <= `PCM_RT_PCS10;
         line_rate_q     <= `PCM_RATE_10G3;
         host_rate_q     <= `PCM_RATE_10G3;
         stage_bypass_q  <= 1'b1;
         rate_fifo_sel_q <= 1'b1;
      end else begin
         stage_bypass_q  <= !stages_en || is_rpt;
         rate_fifo_sel_q <= !mac_en;
         case (mode_q)
            `PCM_MODE_WAN: begin
               rx_route_q  <= `PCM_RT_WIS_PCS10;
               line_rate_q <= `PCM_RATE_9G95;
               host_rate_q <= `PCM_RATE_10G3;
            end
            `PCM_MODE_GBE: begin
               rx_route_q  <= `PCM_RT_PCS1;
               line_rate_q <= `PCM_RATE_1G25;
               host_rate_q <= `PCM_RATE_1G25;
            end
            `PCM_MODE_RPT: begin
               rx_route_q  <= `PCM_RT_REPEAT;
               line_rate_q <= rpt_rate(rpt_rate_sel);
               host_rate_q <= rpt_rate(rpt_rate_sel);
            end
            default: begin
               rx_route_q  <= `PCM_RT_PCS10;
               line_rate_q <= (cru_1g_sel_q && an_done_q) ? `PCM_RATE_1G25
                                                          : `PCM_RATE_10G3;
               host_rate_q <= `PCM_RATE_10G3;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Elastic buffer and repeater clock synchronizer
   // ----------------------------------------------------------------
   // Array holds words between receive and transmit phases
   reg [DW-1:0] ebuf [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_q;
   reg [AW-1:0] rd_ptr_q;
   reg [AW:0]   fill_q;
   reg [AW+`PCM_SYNC_SHIFT:0] phase_acc_q;
   reg          rd_on_q;
   wire [AW:0]  half = DEPTH[AW:0] >> 1;
   wire         wr_go = run && rx_valid && (fill_q != DEPTH[AW:0]);
   // Low-pass filtered fill level paces reads, absorbing wander
   wire [AW:0]  filt = phase_acc_q[AW+`PCM_SYNC_SHIFT:`PCM_SYNC_SHIFT];
   // Reads start at half fill, then run until empty so no word is stranded
   wire         rd_go = run && (fill_q != {(AW+1){1'b0}}) && (rd_on_q || filt >= half || fill_q > half);

   always @(posedge core_clk) begin
      if (wr_go)
         ebuf[wr_ptr_q] <= rx_data;
   end

   // Pointers, fill and the filtering synchronizer loop
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_q      <= {AW{1'b0}};
         rd_ptr_q      <= {AW{1'b0}};
         fill_q        <= {(AW+1){1'b0}};
         phase_acc_q   <= {(AW+`PCM_SYNC_SHIFT+1){1'b0}};
         elastic_ovf_q <= 1'b0;
         rd_on_q       <= 1'b0;
      end else if (path_rst) begin
         wr_ptr_q      <= {AW{1'b0}};
         rd_ptr_q      <= {AW{1'b0}};
         fill_q        <= {(AW+1){1'b0}};
         phase_acc_q   <= {(AW+`PCM_SYNC_SHIFT+1){1'b0}};
         elastic_ovf_q <= 1'b0;
         rd_on_q       <= 1'b0;
      end else begin
         // Read run ends only when the buffer is empty
         if (fill_q == {(AW+1){1'b0}})
            rd_on_q <= 1'b0;
         else if (filt >= half || fill_q > half)
            rd_on_q <= 1'b1;
         if (wr_go)
            wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
         if (rd_go)
            rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
         fill_q <= fill_q + {{AW{1'b0}}, wr_go} - {{AW{1'b0}}, rd_go};
         // First order filter: acc += fill - acc>>shift
         phase_acc_q <= phase_acc_q + {{`PCM_SYNC_SHIFT{1'b0}}, fill_q} - {{`PCM_SYNC_SHIFT{1'b0}}, filt};
         if (rx_valid && !wr_go)
            elastic_ovf_q <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Data steering to host and line outputs
   // ----------------------------------------------------------------
   // Repeater reads from buffer; loopback returns receive data to line
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         host_valid_q <= 1'b0;
         host_data_q  <= {DW{1'b0}};
         line_valid_q <= 1'b0;
         line_data_q  <= {DW{1'b0}};
      end else if (!run) begin
         host_valid_q <= 1'b0;
         line_valid_q <= 1'b0;
      end else begin
         if (is_rpt) begin
            host_valid_q <= rd_go;
            host_data_q  <= ebuf[rd_ptr_q];
         end else begin
            host_valid_q <= rx_valid;
            host_data_q  <= rx_data;
         end
         if (loopback_en) begin
            line_valid_q <= rx_valid;
            line_data_q  <= rx_data;
         end else begin
            line_valid_q <= tx_valid;
            line_data_q  <= tx_data;
         end
      end
   end

   // ----------------------------------------------------------------
   // Signal monitor gating
   // ----------------------------------------------------------------
   // Monitor refused in 1G; unity gain freezes equalization
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         monitor_on_q <= 1'b0;
         dfe_zero_q   <= 1'b0;
         adapt_en_q   <= 1'b1;
      end else begin
         monitor_on_q <= monitor_req && !is_1g;
         dfe_zero_q   <= monitor_req && !is_1g && monitor_unity;
         adapt_en_q   <= !(monitor_req && !is_1g && monitor_unity);
      end
   end

   // ----------------------------------------------------------------
   // Rate negotiation and parallel detection
   // ----------------------------------------------------------------
   reg [1:0]  an_st_q;
   reg [31:0] pd_cnt_q;
   wire an_side  = an_line_req || an_host_req;
   wire an_enab  = (an_mgmt_mode == 2'h1);
   wire an_force = (an_mgmt_mode == 2'h2);

   // Line side wins when both sides ask for negotiation
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         an_line_on_q <= 1'b0;
         an_host_on_q <= 1'b0;
      end else begin
         an_line_on_q <= an_enab && an_line_req;
         an_host_on_q <= an_enab && an_host_req && !an_line_req;
      end
   end

   // Priority: 10G over 1G, partner pages over signal lock; each timeout flips the recovery rate
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         an_st_q      <= AN_IDLE;
         pd_cnt_q     <= 32'h0;
         cru_1g_sel_q <= 1'b0;
         an_done_q    <= 1'b0;
      end else if (path_rst || is_rpt || mode_q == `PCM_MODE_WAN) begin
         an_st_q   <= AN_IDLE;
         pd_cnt_q  <= 32'h0;
         an_done_q <= 1'b0;
      end else if (an_force) begin
         cru_1g_sel_q <= an_force_1g;
         an_done_q    <= 1'b1;
         an_st_q      <= AN_DONE;
      end else begin
         case (an_st_q)
            AN_IDLE: begin
               if (an_enab && an_side) begin
                  an_st_q  <= AN_WAIT;
                  pd_cnt_q <= 32'h0;
               end
            end
            AN_WAIT: begin
               if (partner_an_seen && (partner_adv_10g || partner_adv_1g)) begin
                  cru_1g_sel_q <= !partner_adv_10g;
                  an_done_q    <= 1'b1;
                  an_st_q      <= AN_DONE;
               end else if (sig_10g_lock || sig_1g_lock) begin
                  cru_1g_sel_q <= !sig_10g_lock;
                  an_done_q    <= 1'b1;
                  an_st_q      <= AN_DONE;
               end else if (pd_cnt_q >= PD_COUNT - 1) begin
                  cru_1g_sel_q <= !cru_1g_sel_q;
                  pd_cnt_q     <= 32'h0;
               end else begin
                  pd_cnt_q <= pd_cnt_q + 32'h1;
               end
            end
            AN_DONE: begin
               if (!an_enab || !an_side) begin
                  an_st_q   <= AN_IDLE;
                  an_done_q <= 1'b0;
               end
            end
            default: an_st_q <= AN_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Transmit equalizer
   // ----------------------------------------------------------------
   pcm_tx_fir #(
      .CW (CW)
   ) u_fir (
      .core_clk  (core_clk),
      .rst_n     (rst_n),
      .bit_en    (ser_bit_en),
      .bit_in    (ser_bit),
      .coef_pre  (coef_pre),
      .coef_main (coef_main),
      .coef_post (coef_post),
      .drive_q   (fir_drive_q)
   );
endmodule // pcm_channel

// File: pcm_map.vh
// Constants of the channel mode data path block
`ifndef PCM_MAP_VH
`define PCM_MAP_VH

// Channel operating modes
`define PCM_MODE_LAN       3'h0
`define PCM_MODE_WAN       3'h1
`define PCM_MODE_GBE       3'h2
`define PCM_MODE_RPT       3'h3

// Repeater sub rates
`define PCM_RPT_LAN        3'h0
`define PCM_RPT_GBE        3'h1
`define PCM_RPT_OTU2       3'h2
`define PCM_RPT_OTU1E      3'h3
`define PCM_RPT_OTU2E      3'h4

// Line and host serial rate codes
`define PCM_RATE_10G3      3'h0
`define PCM_RATE_9G95      3'h1
`define PCM_RATE_1G25      3'h2
`define PCM_RATE_10G7      3'h3
`define PCM_RATE_11G05     3'h4
`define PCM_RATE_11G1      3'h5

// Reference clock select results
`define PCM_REF_156M25     1'b0
`define PCM_REF_125M       1'b1

// Receive route codes
`define PCM_RT_PCS10       3'h0
`define PCM_RT_WIS_PCS10   3'h1
`define PCM_RT_PCS1        3'h2
`define PCM_RT_REPEAT      3'h3

// Negotiation timing: core clock in MHz, parallel detect window in us
`define PCM_CLK_MHZ        20
`define PCM_PD_WAIT_US     500
`define PCM_PD_CYCLES      (`PCM_PD_WAIT_US * `PCM_CLK_MHZ)

// Synchronizer loop filter shift
`define PCM_SYNC_SHIFT     4
`endif

// File: pcm_tx_fir.v
// Three tap transmit equalizer on the serial clock enable
`timescale 1ns/1ps
module pcm_tx_fir #(
   parameter CW = 6
) (
   // Clock and reset
   input  wire              core_clk,
   input  wire              rst_n,
   // Serial bit stream
   input  wire              bit_en,
   input  wire              bit_in,
   // Coefficients
   input  wire [CW-1:0]     coef_pre,
   input  wire [CW-1:0]     coef_main,
   input  wire [CW-1:0]     coef_post,
   // Summed drive level
   output reg  [CW+1:0]     drive_q
);
   reg [2:0] tap_q;

   // Weight a tap bit: polarity picks sign of the coefficient
   function [CW+1:0] weigh;
      input          b;
      input [CW-1:0] c;
      begin
         weigh = b ? {2'b00, c} : ((~{2'b00, c}) + {{(CW+1){1'b0}}, 1'b1});
      end
   endfunction

   // ----------------------------------------------------------------
   // Delay line and summation
   // ----------------------------------------------------------------
   // Three flops give pre, main and post cursor
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tap_q   <= 3'h0;
         drive_q <= {(CW+2){1'b0}};
      end else if (bit_en) begin
         tap_q   <= {tap_q[1:0], bit_in};
         drive_q <= weigh(tap_q[0], coef_pre) + weigh(tap_q[1], coef_main)
                  + weigh(tap_q[2], coef_post);
      end
   end
endmodule // pcm_tx_fir

// File: pcm_channel_sva.sv
// Port checker of the channel mode data path
`timescale 1ns/1ps
`include "pcm_map.vh"
module pcm_chk #(
   parameter DW = 16
) (
   // Clock, reset, mode
   input wire          core_clk,
   input wire          rst_n,
   input wire          path_rst,
   input wire [2:0]    mode_sel,
   input wire          loopback_en,
   // Data
   input wire          rx_valid,
   input wire [DW-1:0] rx_data,
   input wire          host_valid_q,
   input wire [DW-1:0] host_data_q,
   input wire          line_valid_q,
   input wire [DW-1:0] line_data_q,
   // Status
   input wire [2:0]    rx_route_q,
   input wire [2:0]    line_rate_q,
   input wire [2:0]    host_rate_q,
   input wire          monitor_on_q,
   input wire          dfe_zero_q,
   input wire          adapt_en_q,
   // Negotiation
   input wire [1:0]    an_mgmt_mode,
   input wire          an_line_req,
   input wire          an_force_1g,
   input wire          an_line_on_q,
   input wire          an_host_on_q,
   input wire          an_done_q,
   input wire          cru_1g_sel_q
);
   // ------------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   wire live = !path_rst && rx_route_q != `PCM_RT_REPEAT;
   // A latched mode reaches route and rates two edges later
   property p_wan; path_rst && mode_sel == `PCM_MODE_WAN |-> ##2 rx_route_q == `PCM_RT_WIS_PCS10
      && line_rate_q == `PCM_RATE_9G95 && host_rate_q == `PCM_RATE_10G3; endproperty
   a_wan: assert property (p_wan) else $error("wan route or rate wrong");
   property p_lan; path_rst && mode_sel == `PCM_MODE_LAN |-> ##2 rx_route_q == `PCM_RT_PCS10
      && host_rate_q == `PCM_RATE_10G3; endproperty
   a_lan: assert property (p_lan) else $error("lan route wrong");
   property p_gbe; path_rst && mode_sel == `PCM_MODE_GBE |-> ##2 rx_route_q == `PCM_RT_PCS1
      && line_rate_q == `PCM_RATE_1G25 && host_rate_q == `PCM_RATE_1G25; endproperty
   a_gbe: assert property (p_gbe) else $error("gbe route or rate wrong");
   property p_rpt; path_rst && mode_sel == `PCM_MODE_RPT |-> ##2 rx_route_q == `PCM_RT_REPEAT
      && line_rate_q == host_rate_q; endproperty
   a_rpt: assert property (p_rpt) else $error("repeater rates differ");
   // Word for word, one edge later
   property p_data; live && !loopback_en && rx_valid |=> host_valid_q && host_data_q == $past(rx_data);
   endproperty
   a_data: assert property (p_data) else $error("host word lost");
   property p_loop; live && loopback_en && rx_valid |=> line_valid_q && line_data_q == $past(rx_data);
   endproperty
   a_loop: assert property (p_loop) else $error("loopback word lost");
   property p_dfe; dfe_zero_q |-> !adapt_en_q; endproperty
   a_dfe: assert property (p_dfe) else $error("adaption with zeroed taps");
   property p_mon; monitor_on_q |-> rx_route_q != `PCM_RT_PCS1 && line_rate_q != `PCM_RATE_1G25; endproperty
   a_mon: assert property (p_mon) else $error("monitor on at 1G");
   property p_an; !(an_line_on_q && an_host_on_q); endproperty
   a_an: assert property (p_an) else $error("negotiation on both sides");
   property p_frc; live && rx_route_q != `PCM_RT_WIS_PCS10 && an_mgmt_mode == 2'h2 && an_line_req
      |=> an_done_q && cru_1g_sel_q == $past(an_force_1g); endproperty
   a_frc: assert property (p_frc) else $error("forced rate not taken");
   c_rpt: cover property (rx_route_q == `PCM_RT_REPEAT && host_valid_q);
   c_loop: cover property (loopback_en && line_valid_q);
   c_mon: cover property (monitor_on_q && dfe_zero_q);
endmodule // pcm_chk
bind pcm_channel pcm_chk #(.DW(DW)) u_chk (.core_clk, .rst_n, .path_rst, .mode_sel, .loopback_en,
   .rx_valid, .rx_data, .host_valid_q, .host_data_q, .line_valid_q, .line_data_q, .rx_route_q,
   .line_rate_q, .host_rate_q, .monitor_on_q, .dfe_zero_q, .adapt_en_q, .an_mgmt_mode, .an_line_req,
   .an_force_1g, .an_line_on_q, .an_host_on_q, .an_done_q, .cru_1g_sel_q);

// File: pcm_line_model.sv
// Line partner model sending numbered parallel words
`timescale 1ns/1ps
module pcm_line_model (
   // Clock and reset
   input wire         core_clk,
   input wire         rst_n,
   // Bench control
   input wire         en,
   input wire         slow,
   input wire [15:0]  base,
   // Words toward the channel
   output reg         rx_valid,
   output reg  [15:0] rx_data
);
   reg [15:0] k_q;
   reg        ph_q;
   // Idle cycles invert the previous bus value, so the bus alternates between the last word and its inverse
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         k_q      <= 16'h0000;
         ph_q     <= 1'b0;
         rx_valid <= 1'b0;
         rx_data  <= 16'h0000;
      end else begin
         ph_q <= !ph_q;
         if (en && (!slow || ph_q)) begin
            rx_valid <= 1'b1;
            rx_data  <= base + k_q;
            k_q      <= k_q + 16'h0001;
         end else begin
            rx_valid <= 1'b0;
            rx_data  <= ~rx_data;
            if (!en)
               k_q <= 16'h0000;
         end
      end
   end
endmodule // pcm_line_model

// File: pcm_channel_tb.sv
// Self-checking bench of the channel mode data path
`timescale 1ns/1ps
`include "pcm_map.vh"
module pcm_channel_tb;
   reg         core_clk = 1'b0, rst_n = 1'b0, path_rst = 1'b0, stages_en = 1'b1, mac_en = 1'b0;
   reg  [2:0]  mode_sel = 3'h0, rpt_rate_sel = 3'h0;
   reg  [1:0]  refsel_pins = 2'h2, an_mgmt_mode = 2'h0;
   reg         loopback_en = 1'b0, tx_valid = 1'b0, monitor_req = 1'b0, monitor_unity = 1'b0;
   reg  [15:0] tx_data = 16'h0000, base = 16'h0000, exp_h, exp_l;
   reg         an_line_req = 1'b0, an_host_req = 1'b0, an_force_1g = 1'b0, partner_adv_10g = 1'b0;
   reg         partner_adv_1g = 1'b0, partner_an_seen = 1'b0, sig_10g_lock = 1'b0, sig_1g_lock = 1'b0;
   reg         ser_bit_en = 1'b0, ser_bit = 1'b0, en = 1'b0, slow = 1'b0;
   reg  [5:0]  coef_pre = 6'h03, coef_main = 6'h14, coef_post = 6'h05;
   wire        rx_valid, host_valid_q, line_valid_q, ref_sel_q, stage_bypass_q, rate_fifo_sel_q;
   wire        elastic_ovf_q, monitor_on_q, dfe_zero_q, adapt_en_q, an_line_on_q, an_host_on_q;
   wire        cru_1g_sel_q, an_done_q;
   wire [15:0] rx_data, host_data_q, line_data_q;
   wire [2:0]  rx_route_q, line_rate_q, host_rate_q;
   wire [7:0]  fir_drive_q;
   integer     errors = 0, checked = 0, cyc = 0, nh = 0, nl = 0, i, r;
   // ------------------------------------------------------------------
   // Design, partner and clock
   // ------------------------------------------------------------------
   pcm_channel #(.PD_COUNT(16)) u_dut (.core_clk, .rst_n, .path_rst, .mode_sel, .rpt_rate_sel,
      .refsel_pins, .stages_en, .mac_en, .loopback_en, .rx_valid, .rx_data, .host_valid_q, .host_data_q,
      .tx_valid, .tx_data, .line_valid_q, .line_data_q, .rx_route_q, .line_rate_q, .host_rate_q,
      .ref_sel_q, .stage_bypass_q, .rate_fifo_sel_q, .elastic_ovf_q, .monitor_req, .monitor_unity,
      .monitor_on_q, .dfe_zero_q, .adapt_en_q, .an_line_req, .an_host_req, .an_mgmt_mode, .an_force_1g,
      .partner_adv_10g, .partner_adv_1g, .partner_an_seen, .sig_10g_lock, .sig_1g_lock, .an_line_on_q,
      .an_host_on_q, .cru_1g_sel_q, .an_done_q, .ser_bit_en, .ser_bit, .coef_pre, .coef_main,
      .coef_post, .fir_drive_q);
   pcm_line_model u_line (.core_clk, .rst_n, .en, .slow, .base, .rx_valid, .rx_data);
   always #25 core_clk = ~core_clk;
   task chk(input [15:0] got, input [15:0] exp);
      begin
         checked = checked + 1;
         if (got !== exp) begin
            errors = errors + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task test_done;
      begin
         $display("errors %0d checked %0d", errors, checked);
         if (errors == 0 && checked > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask
   // Words leave in arrival order; the timeout guards a stalled path
   always @(posedge core_clk) begin
      cyc = cyc + 1;
      if (cyc == 6000) begin
         errors = errors + 1;
         test_done;
      end
      if (host_valid_q === 1'b1) begin
         chk(host_data_q, exp_h);
         exp_h = exp_h + 16'h0001;
         nh = nh + 1;
      end
      if (line_valid_q === 1'b1) begin
         chk(line_data_q, exp_l);
         exp_l = exp_l + 16'h0001;
         nl = nl + 1;
      end
   end
   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task t_mode(input [2:0] m, input [2:0] rr, input [2:0] rt, input [2:0] lr, input [2:0] hr, input b);
      begin
         @(posedge core_clk);
         path_rst <= 1'b1;
         mode_sel <= m;
         rpt_rate_sel <= rr;
         repeat (3) @(posedge core_clk);
         path_rst <= 1'b0;
         repeat (2) @(negedge core_clk);
         chk(rx_route_q, rt);
         chk(line_rate_q, lr);
         chk(host_rate_q, hr);
         chk(stage_bypass_q, b);
      end
   endtask
   task t_data(input [15:0] b, input lp, input sl, input [15:0] n);
      begin
         @(negedge core_clk);
         exp_h = b;
         exp_l = b;
         nh = 0;
         nl = 0;
         @(posedge core_clk);
         base <= b;
         loopback_en <= lp;
         slow <= sl;
         en <= 1'b1;
         repeat (10) @(posedge core_clk);
         en <= 1'b0;
         repeat (14) @(negedge core_clk);
         chk(lp ? nl : nh, n);
         chk(elastic_ovf_q, 0);
         @(posedge core_clk);
         loopback_en <= 1'b0;
      end
   endtask
   task t_fir(input b, input [7:0] e);
      begin
         @(posedge core_clk);
         ser_bit <= b;
         repeat (8) @(negedge core_clk);
         chk(fir_drive_q, e);
      end
   endtask
   initial begin
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge core_clk);
      refsel_pins <= 2'h0;
      @(negedge core_clk);
      chk(ref_sel_q, `PCM_REF_125M);
      chk(rate_fifo_sel_q, 1);
      @(posedge core_clk);
      mac_en <= 1'b1;
      t_mode(`PCM_MODE_WAN, 0, `PCM_RT_WIS_PCS10, `PCM_RATE_9G95, `PCM_RATE_10G3, 0);
      chk(rate_fifo_sel_q, 0);
      t_mode(`PCM_MODE_GBE, 0, `PCM_RT_PCS1, `PCM_RATE_1G25, `PCM_RATE_1G25, 0);
      t_data(16'h1000, 0, 0, 10);
      t_mode(`PCM_MODE_LAN, 0, `PCM_RT_PCS10, `PCM_RATE_10G3, `PCM_RATE_10G3, 0);
      t_data(16'h2000, 0, 1, 5);
      t_data(16'h3000, 1, 0, 10);
      // Monitor with unity gain at 10G, then refused at 1G
      monitor_req <= 1'b1;
      monitor_unity <= 1'b1;
      repeat (3) @(negedge core_clk);
      chk({monitor_on_q, dfe_zero_q, adapt_en_q}, 3'h6);
      @(posedge core_clk);
      monitor_req <= 1'b0;
      t_mode(`PCM_MODE_GBE, 0, `PCM_RT_PCS1, `PCM_RATE_1G25, `PCM_RATE_1G25, 0);
      @(posedge core_clk);
      monitor_req <= 1'b1;
      repeat (3) @(negedge core_clk);
      chk(monitor_on_q, 0);
      @(posedge core_clk);
      monitor_req <= 1'b0;
      for (r = 0; r < 5; r = r + 1)
         t_mode(`PCM_MODE_RPT, r, `PCM_RT_REPEAT, r ? r + 1 : 0, r ? r + 1 : 0, 1);
      t_data(16'h4000, 0, 0, 10);
      // Both sides ask; partner offers both rates and 10G wins
      an_line_req <= 1'b1;
      an_host_req <= 1'b1;
      an_mgmt_mode <= 2'h1;
      partner_an_seen <= 1'b1;
      partner_adv_10g <= 1'b1;
      partner_adv_1g <= 1'b1;
      t_mode(`PCM_MODE_LAN, 0, `PCM_RT_PCS10, `PCM_RATE_10G3, `PCM_RATE_10G3, 0);
      for (i = 0; i < 60 && an_done_q !== 1'b1; i = i + 1)
         @(negedge core_clk);
      chk({an_done_q, cru_1g_sel_q, an_host_on_q, an_line_on_q}, 4'h9);
      // Silent partner locked at 1G is found by parallel detection
      @(posedge core_clk);
      partner_an_seen <= 1'b0;
      sig_1g_lock <= 1'b1;
      t_mode(`PCM_MODE_GBE, 0, `PCM_RT_PCS1, `PCM_RATE_1G25, `PCM_RATE_1G25, 0);
      for (i = 0; i < 200 && an_done_q !== 1'b1; i = i + 1)
         @(negedge core_clk);
      chk({an_done_q, cru_1g_sel_q}, 2'h3);
      @(posedge core_clk);
      an_mgmt_mode <= 2'h2;
      repeat (2) @(negedge core_clk);
      chk({an_done_q, cru_1g_sel_q}, 2'h2);
      // No partner at all: detection flips the recovery rate after PD_COUNT cycles
      @(posedge core_clk);
      an_mgmt_mode <= 2'h1;
      sig_1g_lock <= 1'b0;
      t_mode(`PCM_MODE_GBE, 0, `PCM_RT_PCS1, `PCM_RATE_1G25, `PCM_RATE_1G25, 0);
      repeat (16) @(negedge core_clk);
      chk({an_done_q, cru_1g_sel_q}, 2'h1);
      // Equalizer: steady levels, then a lone pulse walks pre, main, post
      @(posedge core_clk);
      ser_bit_en <= 1'b1;
      t_fir(1, 8'h1C);
      t_fir(0, 8'hE4);
      @(posedge core_clk);
      ser_bit <= 1'b1;
      @(posedge core_clk);
      ser_bit <= 1'b0;
      for (i = 0; i < 6 && fir_drive_q === 8'hE4; i = i + 1)
         @(negedge core_clk);
      chk(fir_drive_q, 8'hEA);
      @(negedge core_clk);
      chk(fir_drive_q, 8'h0C);
      @(negedge core_clk);
      chk(fir_drive_q, 8'hEE);
      test_done;
   end
endmodule // pcm_channel_tb
